// File: core/msdp_pkg.sv
// Constants, opcodes and state encoding of the monitor serial debug port
package msdp_pkg;
	// ****************************************
	// Serial timing, in bus clocks, bits and slot numbers
	// ****************************************
	localparam logic [8:0] BIT_CYCLES = 9'h116;
	localparam logic [8:0] HALF_BIT = BIT_CYCLES >> 1;
	localparam logic [3:0] RX_LAST_SLOT = 4'h9;
	localparam logic [3:0] TX_LAST_SLOT = 4'hb;
	localparam logic [1:0] GAP_ONES = 2'h3;
	localparam logic [11:0] CANCEL_BITS = 12'h00b;
	localparam logic [11:0] CANCEL_CYCLES = CANCEL_BITS * {3'h0, BIT_CYCLES};

	// ****************************************
	// Commands and data values
	// ****************************************
	localparam logic [7:0] OP_INDEXED_READ = 8'h1a;
	localparam logic [7:0] OP_READ_STACK = 8'h0c;
	localparam logic [7:0] OP_RUN = 8'h28;
	localparam logic [3:0] SEC_LAST = 4'h7;
	localparam logic [7:0] LOCKED_DATA = 8'h00;
	localparam logic [15:0] FLASH_BASE = 16'h8000;
	localparam logic [7:0] RAM_FLAG_ADDR = 8'h40;
	localparam logic [7:0] RAM_FLAG_BIT = 8'h40;
	localparam logic [15:0] SP_RETURN_OFS = 16'h0001;
	localparam logic [15:0] PC_HIGH_OFS = 16'h0005;
	localparam logic [15:0] PC_LOW_OFS = 16'h0006;
	localparam logic [1:0] READ_BYTES = 2'h2;

	// ****************************************
	// Vector addresses
	// ****************************************
	localparam logic [15:0] VEC_RESET_USER = 16'hfffe;
	localparam logic [15:0] VEC_RESET_MON = 16'hfefe;
	localparam logic [15:0] VEC_SWI_USER = 16'hfffc;
	localparam logic [15:0] VEC_SWI_MON = 16'hfefc;

	// ****************************************
	// Transmit queue
	// ****************************************
	localparam int FIFO_WIDTH = 9;
	localparam int FIFO_DEPTH = 8;

	typedef enum logic [7:0] {
		ST_OFF = 8'h01,
		ST_SEC = 8'h02,
		ST_READY = 8'h04,
		ST_IDLE = 8'h08,
		ST_HOLD = 8'h10,
		ST_FETCH = 8'h20,
		ST_CATCH = 8'h40,
		ST_PUSH = 8'h80
	} msdp_state_t;
endpackage

// File: core/msdp_fifo_if.sv
// Interface carrying the transmit queue handshakes
`timescale 1ns/1ps
interface msdp_fifo_if;
	logic wrValid;
	logic wrReady;
	logic [8:0] wrData;
	logic rdValid;
	logic rdReady;
	logic [8:0] rdData;
	modport store (input wrValid, wrData, rdReady,
		output wrReady, rdValid, rdData);
	modport user (output wrValid, wrData, rdReady,
		input wrReady, rdValid, rdData);
endinterface

// File: core/msdp_fifo.sv
// Small synchronous FIFO with a registered read word
`timescale 1ns/1ps
module msdp_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	input wire logic core_clk,
	input wire logic rst,
	msdp_fifo_if.store port
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr;
	logic [AW-1:0] rdPtr;
	logic [AW:0] count;
	logic outValid;
	logic [WIDTH-1:0] outData;
	wire push = port.wrValid && port.wrReady;
	wire pop = (count != '0) && (!outValid || port.rdReady);

	assign port.wrReady = (count != (AW+1)'(DEPTH));
	assign port.rdValid = outValid;
	assign port.rdData = outData;

	always_ff @(posedge core_clk) begin
		if (push)
			mem[wrPtr] <= port.wrData;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else begin
			if (push)
				wrPtr <= wrPtr + 1'b1;
			if (pop)
				rdPtr <= rdPtr + 1'b1;
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// Read word lives in a register so the drain side sees clean data
	always_ff @(posedge core_clk) begin
		if (rst) begin
			outValid <= 1'b0;
			outData <= '0;
		end else if (pop) begin
			outValid <= 1'b1;
			outData <= mem[rdPtr];
		end else if (port.rdReady) begin
			outValid <= 1'b0;
		end
	end
endmodule

// File: core/msdp_port.sv
// Monitor serial debug port: mode entry, serial link, commands, security
//
// Contract
// - forced entry ignores baud select pin
// - blank vector entry after power-on adds one reset
// - supply-level request pin selects clock divide-by-four
// - ground request pin turns on internal clock
// - forced mode always disables the watchdog
// - monitor mode uses the alternate vector page
// - same bit rate both directions
// - break is start plus nine lows
// - on break, idle two bits, echo break
// - bit period is 278 bus clocks
// - every received byte is echoed (code drops a frame with a low stop bit and nonzero data, no echo)
// - eleven bit wait, break cancels command
// - two bit gap before each sent byte
// - read data follows the final echo
// - indexed read returns next two bytes
// - read stack returns SP plus one
// - run pulls index high and returns
// - entry does software interrupt, pushes index
// - eight matching bytes unlock until power-on
// - mismatch gives invalid reads, illegal fetch reset
// - ready break after security, flag bit six
// - mode latched on reset pin rise
// - line is wired-OR, only driven low
`timescale 1ns/1ps
module msdp_port
	import msdp_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic serialLineIn,
	output logic serialLineOut,
	output logic serialLineDriveN,
	input wire logic resetPinN,
	input wire logic testHighVoltage,
	input wire logic irqPinHigh,
	input wire logic baudSelectPin,
	input wire logic resetVectorBlank,
	input wire logic [63:0] securityCode,
	input wire logic [15:0] stackPointer,
	input wire logic lastAccessLoad,
	input wire logic [15:0] lastAccessAddr,
	output logic [15:0] memAddr,
	output logic memRead,
	input wire logic [7:0] memReadData,
	input wire logic flashFetch,
	output logic monitorMode,
	output logic busDivFourSel,
	output logic internalClockGenOn,
	output logic baudAltSel,
	output logic watchdogDisable,
	output logic [15:0] resetVector,
	output logic [15:0] swiVector,
	output logic extraReset,
	output logic swiEntry,
	output logic [15:0] stackPcHighAddr,
	output logic [15:0] stackPcLowAddr,
	output logic runPulse,
	output logic flashUnlocked,
	output logic illegalAddrReset,
	output logic ramFlagSet,
	output logic [7:0] ramFlagAddr,
	output logic [7:0] ramFlagData
);
	// ****************************************
	// Functions
	// ****************************************
	function automatic logic [7:0] secByte(input logic [63:0] code,
		input logic [3:0] idx);
		secByte = code[{idx[2:0], 3'h0} +: 8];
	endfunction

	function automatic logic [15:0] offsetAddr(input logic [15:0] base,
		input logic [15:0] ofs);
		offsetAddr = base + ofs;
	endfunction

	// ****************************************
	// Pin synchronisers and mode capture
	// ****************************************
	logic [4:0] pinMeta;
	logic [4:0] pinSync;
	logic rstPrev;
	logic captured;
	logic tstCap;
	logic irqHiCap;
	logic baudCap;
	logic blankCap;
	logic entryDly;
	logic porSeen;
	wire lineS = pinSync[4];
	wire baudS = pinSync[3];
	wire irqHiS = pinSync[2];
	wire tstS = pinSync[1];
	wire rstPinS = pinSync[0];
	wire rstRise = rstPinS && !rstPrev;
	wire normalNow = captured && tstCap;
	wire forcedNow = captured && !tstCap && blankCap;
	wire monitorNow = normalNow || forcedNow;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			pinMeta <= 5'h10;
			pinSync <= 5'h10;
		end else begin
			pinMeta <= {serialLineIn, baudSelectPin, irqPinHigh,
				testHighVoltage, resetPinN};
			pinSync <= pinMeta;
		end
	end

	// Pins other than the test pin may change freely once this edge has passed; normal-mode watchdogDisable follows tstS live
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rstPrev <= 1'b0;
			captured <= 1'b0;
			tstCap <= 1'b0;
			irqHiCap <= 1'b0;
			baudCap <= 1'b0;
			blankCap <= 1'b0;
		end else begin
			rstPrev <= rstPinS;
			if (!rstPinS)
				captured <= 1'b0;
			else if (rstRise) begin
				captured <= 1'b1;
				tstCap <= tstS;
				irqHiCap <= irqHiS;
				baudCap <= baudS;
				blankCap <= resetVectorBlank;
			end
		end
	end

	// rst stands for the power-on reset; the pin reset keeps porSeen clear
	always_ff @(posedge core_clk) begin
		if (rst) begin
			entryDly <= 1'b0;
			porSeen <= 1'b1;
			extraReset <= 1'b0;
			swiEntry <= 1'b0;
		end else begin
			entryDly <= rstRise;
			extraReset <= entryDly && forcedNow && porSeen;
			swiEntry <= entryDly && monitorNow;
			if (entryDly)
				porSeen <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			monitorMode <= 1'b0;
			busDivFourSel <= 1'b0;
			internalClockGenOn <= 1'b1;
			baudAltSel <= 1'b0;
			watchdogDisable <= 1'b0;
			resetVector <= VEC_RESET_USER;
			swiVector <= VEC_SWI_USER;
		end else begin
			monitorMode <= monitorNow;
			busDivFourSel <= normalNow || (forcedNow && irqHiCap);
			internalClockGenOn <= !monitorNow || !irqHiCap;
			baudAltSel <= normalNow && baudCap;
			watchdogDisable <= forcedNow || (normalNow && tstS);
			resetVector <= monitorNow ? VEC_RESET_MON : VEC_RESET_USER;
			swiVector <= monitorNow ? VEC_SWI_MON : VEC_SWI_USER;
		end
	end

	// ****************************************
	// Receiver
	// ****************************************
	logic rxActive;
	logic rxWaitHigh;
	logic [8:0] rxCnt;
	logic [3:0] rxSlot;
	logic [8:0] rxShift;
	logic rxPend;
	logic rxIsBreak;
	logic [7:0] rxData;
	logic txBusy;
	msdp_fifo_if txq ();
	wire rxTake = rxPend && txq.wrReady;
	// Own transmission reads back on the wired-OR line, so ignore it
	wire rxEnable = monitorMode && !txBusy && !rxPend;
	wire rxStart = !rxActive && rxEnable && !rxWaitHigh && !lineS;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rxActive <= 1'b0;
			rxWaitHigh <= 1'b0;
			rxCnt <= '0;
			rxSlot <= '0;
			rxShift <= '0;
			rxPend <= 1'b0;
			rxIsBreak <= 1'b0;
			rxData <= '0;
		end else begin
			if (rxTake)
				rxPend <= 1'b0;
			if (lineS)
				rxWaitHigh <= 1'b0;
			if (rxStart) begin
				rxActive <= 1'b1;
				rxCnt <= HALF_BIT;
				rxSlot <= '0;
			end else if (rxActive && rxCnt != '0) begin
				rxCnt <= rxCnt - 1'b1;
			end else if (rxActive) begin
				rxCnt <= BIT_CYCLES - 1'b1;
				rxSlot <= rxSlot + 1'b1;
				rxShift <= {lineS, rxShift[8:1]};
				if (rxSlot == '0 && lineS)
					rxActive <= 1'b0;
				if (rxSlot == RX_LAST_SLOT) begin
					rxActive <= 1'b0;
					rxWaitHigh <= !lineS;
					rxData <= rxShift[8:1];
					rxIsBreak <= !lineS;
					rxPend <= lineS || (rxShift[8:1] == 8'h00);
				end
			end
		end
	end

	// ****************************************
	// Transmit queue and transmitter
	// ****************************************
	logic [8:0] txCnt;
	logic [3:0] txSlot;
	logic [11:0] txShift;
	logic txIsBreak;
	msdp_state_t st;
	logic [15:0] sendBuf;
	wire fsmWant = (st == ST_READY) || (st == ST_PUSH);
	wire fsmTake = fsmWant && !rxPend && txq.wrReady;
	wire [8:0] fsmData = (st == ST_READY) ? 9'h100 : {1'b0, sendBuf[15:8]};
	wire txPop = txq.rdValid && !txBusy;
	// Two idle slots lead every character, a break is ten lows
	wire [11:0] txFrame = txq.rdData[8] ? {10'h000, GAP_ONES}
		: {1'b1, txq.rdData[7:0], 1'b0, GAP_ONES};

	assign txq.wrValid = rxPend || (fsmWant && !rxPend);
	assign txq.wrData = rxPend ? {rxIsBreak, rxData} : fsmData;
	assign txq.rdReady = !txBusy;
	assign serialLineOut = 1'b0;
	assign serialLineDriveN = !(txBusy && !txShift[0]);

	msdp_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_txq (
		.core_clk(core_clk),
		.rst(rst),
		.port(txq.store)
	);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			txBusy <= 1'b0;
			txCnt <= '0;
			txSlot <= '0;
			txShift <= 12'hfff;
			txIsBreak <= 1'b0;
		end else if (txPop) begin
			txBusy <= 1'b1;
			txCnt <= BIT_CYCLES - 1'b1;
			txSlot <= '0;
			txShift <= txFrame;
			txIsBreak <= txq.rdData[8];
		end else if (txBusy && txCnt != '0) begin
			txCnt <= txCnt - 1'b1;
		end else if (txBusy) begin
			txCnt <= BIT_CYCLES - 1'b1;
			txSlot <= txSlot + 1'b1;
			txShift <= {1'b1, txShift[11:1]};
			if (txSlot == TX_LAST_SLOT)
				txBusy <= 1'b0;
		end
	end

	// ****************************************
	// Command engine and security check
	// ****************************************
	logic [3:0] secIdx;
	logic secBad;
	logic [7:0] opcode;
	logic [11:0] holdCnt;
	logic [15:0] ptr;
	logic [1:0] sendCnt;
	logic isIndexed;
	wire txIdle = !txBusy && !txq.rdValid;
	wire secMiss = rxData != secByte(securityCode, secIdx);
	wire lockedFlash = !flashUnlocked && memAddr >= FLASH_BASE;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st <= ST_OFF;
			secIdx <= '0;
			secBad <= 1'b0;
			opcode <= '0;
			holdCnt <= '0;
			ptr <= '0;
			sendCnt <= '0;
			isIndexed <= 1'b0;
			sendBuf <= '0;
			memAddr <= '0;
			memRead <= 1'b0;
			runPulse <= 1'b0;
			flashUnlocked <= 1'b0;
			ramFlagSet <= 1'b0;
		end else begin
			runPulse <= 1'b0;
			ramFlagSet <= 1'b0;
			memRead <= 1'b0;
			if (lastAccessLoad)
				ptr <= lastAccessAddr;
			case (st)
			ST_OFF: begin
				secIdx <= '0;
				secBad <= 1'b0;
				if (swiEntry)
					st <= flashUnlocked ? ST_READY : ST_SEC;
			end
			ST_SEC: begin
				if (rxTake && !rxIsBreak) begin
					secIdx <= secIdx + 1'b1;
					secBad <= secBad || secMiss;
					if (secIdx == SEC_LAST) begin
						flashUnlocked <= !(secBad || secMiss);
						ramFlagSet <= !(secBad || secMiss);
						st <= ST_READY;
					end
				end
			end
			ST_READY: begin
				if (fsmTake)
					st <= ST_IDLE;
			end
			ST_IDLE: begin
				if (rxTake && !rxIsBreak) begin
					opcode <= rxData;
					holdCnt <= CANCEL_CYCLES;
					st <= ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (rxTake && rxIsBreak) begin
					st <= ST_IDLE;
				end else if (holdCnt != '0) begin
					if (txIdle)
						holdCnt <= holdCnt - 1'b1;
				end else begin
					st <= ST_IDLE;
					sendCnt <= READ_BYTES;
					if (opcode == OP_INDEXED_READ) begin
						isIndexed <= 1'b1;
						st <= ST_FETCH;
					end else if (opcode == OP_READ_STACK) begin
						isIndexed <= 1'b0;
						sendBuf <= offsetAddr(stackPointer, SP_RETURN_OFS);
						st <= ST_PUSH;
					end else if (opcode == OP_RUN) begin
						runPulse <= 1'b1;
					end
				end
			end
			ST_FETCH: begin
				memAddr <= offsetAddr(ptr, SP_RETURN_OFS);
				ptr <= offsetAddr(ptr, SP_RETURN_OFS);
				memRead <= 1'b1;
				st <= ST_CATCH;
			end
			ST_CATCH: begin
				sendBuf[15:8] <= lockedFlash ? LOCKED_DATA : memReadData;
				st <= ST_PUSH;
			end
			ST_PUSH: begin
				if (fsmTake) begin
					sendCnt <= sendCnt - 1'b1;
					sendBuf <= {sendBuf[7:0], 8'h00};
					if (sendCnt == 2'h1)
						st <= ST_IDLE;
					else if (isIndexed)
						st <= ST_FETCH;
				end
			end
			default: st <= ST_OFF;
			endcase
			if (!monitorMode && st != ST_OFF)
				st <= ST_OFF;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			illegalAddrReset <= 1'b0;
			stackPcHighAddr <= '0;
			stackPcLowAddr <= '0;
		end else begin
			illegalAddrReset <= monitorMode && !flashUnlocked && flashFetch;
			stackPcHighAddr <= offsetAddr(stackPointer, PC_HIGH_OFS);
			stackPcLowAddr <= offsetAddr(stackPointer, PC_LOW_OFS);
		end
	end

	assign ramFlagAddr = RAM_FLAG_ADDR;
	assign ramFlagData = RAM_FLAG_BIT;

	// ****************************************
	// Assertions
	// ****************************************
	a_forced_no_baud: assert property (@(posedge core_clk)
		disable iff (rst) $past(forcedNow) |-> !baudAltSel)
		else $error("baud select used in forced mode");
	a_forced_watchdog: assert property (@(posedge core_clk)
		disable iff (rst) $past(forcedNow) |-> watchdogDisable)
		else $error("watchdog enabled in forced mode");
	a_monitor_vector: assert property (@(posedge core_clk)
		disable iff (rst) monitorMode |->
		resetVector == VEC_RESET_MON && swiVector == VEC_SWI_MON)
		else $error("user vector page in monitor mode");
	a_break_lows: assert property (@(posedge core_clk)
		disable iff (rst) txBusy && txIsBreak && txSlot >= 4'h2 |->
		!serialLineDriveN)
		else $error("break character released the line");
	a_echo_gap: assert property (@(posedge core_clk)
		disable iff (rst) txBusy && txSlot < 4'h2 |-> serialLineDriveN)
		else $error("line driven during leading gap");
	a_echo_queued: assert property (@(posedge core_clk)
		disable iff (rst) $rose(rxPend) && txq.wrReady |=>
		!rxPend && $past(txq.wrData) == {rxIsBreak, rxData})
		else $error("received byte not echoed");
	a_cancel_wait: assert property (@(posedge core_clk)
		disable iff (rst) st == ST_IDLE && rxTake && !rxIsBreak |=>
		st == ST_HOLD && holdCnt == CANCEL_CYCLES)
		else $error("command wait not started");
	a_run_cause: assert property (@(posedge core_clk)
		disable iff (rst) runPulse |-> opcode == OP_RUN &&
		$past(st) == ST_HOLD)
		else $error("run pulse without run command");
	a_locked_read: assert property (@(posedge core_clk)
		disable iff (rst) st == ST_CATCH && lockedFlash |=>
		sendBuf[15:8] == LOCKED_DATA)
		else $error("locked flash data returned");
endmodule

// File: sim/msdp_host_model.sv
// Host computer model on the wired-OR monitor serial line
`timescale 1ns/1ps
module msdp_host_model
	import msdp_pkg::*;
(
	input wire logic core_clk,
	input wire logic line,
	output logic hostLevel
);
	localparam int BITC = int'(BIT_CYCLES);

	initial begin
		hostLevel = 1'b1;
	end

	// ****************************************
	// Transmit: released line reads high through the pull-up
	// ****************************************
	task automatic send_byte(input logic [7:0] data);
		logic [9:0] slots;
		slots = {1'b1, data, 1'b0};
		// Idle first, so a call right after rx never crowds the echo's stop bit
		repeat (BITC + BITC / 2) @(posedge core_clk);
		for (int i = 0; i < 10; i++) begin
			#1 hostLevel <= slots[i];
			repeat (BITC) @(posedge core_clk);
		end
	endtask

	// ****************************************
	// Receive: sampled mid-bit; gap counts idle cycles before start
	// ****************************************
	task automatic recv(input int limit, output logic [7:0] data,
		output logic isBreak, output int gap, output logic ok);
		logic stopBit;
		gap = 0;
		data = 8'h00;
		isBreak = 1'b0;
		ok = 1'b0;
		while (line !== 1'b0 && gap < limit) begin
			@(posedge core_clk);
			gap++;
		end
		if (gap < limit) begin
			repeat (BITC / 2) @(posedge core_clk);
			ok = (line === 1'b0);
			for (int i = 0; i < 8; i++) begin
				repeat (BITC) @(posedge core_clk);
				data[i] = line;
			end
			repeat (BITC) @(posedge core_clk);
			stopBit = line;
			isBreak = (stopBit === 1'b0) && (data === 8'h00);
			ok = ok && (isBreak || stopBit === 1'b1);
		end
	endtask
endmodule

// File: sim/msdp_port_tb.sv
// Self-checking bench of the monitor serial debug port
`timescale 1ns/1ps
module msdp_port_tb;
	import msdp_pkg::*;
	localparam int BITC = int'(BIT_CYCLES);
	logic core_clk, rst, line, hostLevel, serialLineOut, serialLineDriveN;
	logic resetPinN, testHighVoltage, irqPinHigh, baudSelectPin;
	logic resetVectorBlank, lastAccessLoad, memRead, flashFetch;
	logic monitorMode, busDivFourSel, internalClockGenOn, baudAltSel;
	logic watchdogDisable, extraReset, swiEntry, runPulse, flashUnlocked;
	logic illegalAddrReset, ramFlagSet;
	logic [63:0] securityCode;
	logic [15:0] stackPointer, lastAccessAddr, memAddr, resetVector;
	logic [15:0] swiVector, stackPcHighAddr, stackPcLowAddr;
	logic [7:0] memReadData, ramFlagAddr, ramFlagData;
	int miscompares = 0;
	int compares = 0;
	int extraCount = 0;
	int swiCount = 0;
	int flagCount = 0;
	int runCount = 0;

	// Memory contents depend on the address so a wrong pointer shows
	function automatic logic [7:0] memv(input logic [15:0] a);
		return a[7:0] ^ 8'h5a;
	endfunction

	assign line = hostLevel & (serialLineDriveN | serialLineOut);
	// Data only while the read strobe stands, so a missed strobe shows
	assign memReadData = memRead ? memv(memAddr) : 8'h00;

	msdp_port uut (.core_clk(core_clk), .rst(rst),
		.serialLineIn(line), .serialLineOut(serialLineOut),
		.serialLineDriveN(serialLineDriveN), .resetPinN(resetPinN),
		.testHighVoltage(testHighVoltage), .irqPinHigh(irqPinHigh),
		.baudSelectPin(baudSelectPin), .resetVectorBlank(resetVectorBlank),
		.securityCode(securityCode), .stackPointer(stackPointer),
		.lastAccessLoad(lastAccessLoad), .lastAccessAddr(lastAccessAddr),
		.memAddr(memAddr), .memRead(memRead), .memReadData(memReadData),
		.flashFetch(flashFetch), .monitorMode(monitorMode),
		.busDivFourSel(busDivFourSel),
		.internalClockGenOn(internalClockGenOn), .baudAltSel(baudAltSel),
		.watchdogDisable(watchdogDisable), .resetVector(resetVector),
		.swiVector(swiVector), .extraReset(extraReset), .swiEntry(swiEntry),
		.stackPcHighAddr(stackPcHighAddr), .stackPcLowAddr(stackPcLowAddr),
		.runPulse(runPulse), .flashUnlocked(flashUnlocked),
		.illegalAddrReset(illegalAddrReset), .ramFlagSet(ramFlagSet),
		.ramFlagAddr(ramFlagAddr), .ramFlagData(ramFlagData));

	msdp_host_model host (.core_clk(core_clk), .line(line),
		.hostLevel(hostLevel));

	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		if (extraReset === 1'b1) extraCount++;
		if (swiEntry === 1'b1) swiCount++;
		if (ramFlagSet === 1'b1) flagCount++;
		if (runPulse === 1'b1) runCount++;
	end

	// ****************************************
	// Comparison and reporting
	// ****************************************
	task automatic summarize();
		if (miscompares == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic check_val(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic check_count(input string what, input int exp,
		input int got);
		compares++;
		if (got != exp) begin
			miscompares++;
			$display("unexpected %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	// Gap bounds are in bit periods, from the previous frame's end
	task automatic rx(input string what, input logic [7:0] expData,
		input logic expBreak, input int minGap, input int maxGap);
		logic [7:0] d;
		logic b;
		logic ok;
		int gap;
		host.recv(maxGap * BITC, d, b, gap, ok);
		if (ok !== 1'b1) begin
			miscompares++;
			$display("unexpected %s expected frame seen none", what);
			summarize();
		end else begin
			check_val(what, {8'h00, expData}, {8'h00, d});
			check_val({what, " break"}, {15'h0, expBreak}, {15'h0, b});
			check_count({what, " early"}, 1, int'(gap >= minGap * BITC));
		end
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset_entry();
		check_val("clock gen at reset", 16'h1, {15'h0, internalClockGenOn});
		check_val("line drive at reset", 16'h1, {15'h0, serialLineDriveN});
		check_val("vector at reset", 16'hfffe, resetVector);
		repeat (5) @(posedge core_clk);
		#1 resetPinN = 1'b1;
		repeat (10) @(posedge core_clk);
		// Pins may move once the mode is latched
		#1 baudSelectPin = 1'b0;
		irqPinHigh = 1'b0;
		repeat (5) @(posedge core_clk);
		#1;
		check_val("monitor mode", 16'h1, {15'h0, monitorMode});
		check_val("divide by four", 16'h1, {15'h0, busDivFourSel});
		check_val("forced baud", 16'h0, {15'h0, baudAltSel});
		check_val("clock gen", 16'h0, {15'h0, internalClockGenOn});
		check_val("watchdog off", 16'h1, {15'h0, watchdogDisable});
		check_val("reset vector", 16'hfefe, resetVector);
		check_val("swi vector", 16'hfefc, swiVector);
		check_count("extra resets", 1, extraCount);
		check_count("swi entries", 1, swiCount);
		check_val("pc high slot", 16'h1304, stackPcHighAddr);
		check_val("pc low slot", 16'h1305, stackPcLowAddr);
	endtask

	task automatic t_security();
		for (int i = 0; i < 8; i++) begin
			host.send_byte(securityCode[8*i +: 8]);
			rx("security echo", securityCode[8*i +: 8], 1'b0, 1, 3);
		end
		rx("ready break", 8'h00, 1'b1, 2, 16);
		repeat (4) @(posedge core_clk);
		check_val("unlocked", 16'h1, {15'h0, flashUnlocked});
		check_count("flag writes", 1, flagCount);
		check_val("flag place", 16'h4040, {ramFlagAddr, ramFlagData});
		#1 flashFetch = 1'b1;
		repeat (5) @(posedge core_clk);
		check_val("illegal fetch", 16'h0, {15'h0, illegalAddrReset});
		#1 flashFetch = 1'b0;
	endtask

	// Pin reset into normal mode: no security bytes, ready break at once
	task automatic t_pin_reset();
		// Let the ready break end so the receiver sees an idle line
		repeat (BITC) @(posedge core_clk);
		#1 resetPinN = 1'b0;
		testHighVoltage = 1'b1;
		irqPinHigh = 1'b1;
		baudSelectPin = 1'b1;
		repeat (5) @(posedge core_clk);
		#1;
		check_val("mode in pin reset", 16'h0, {15'h0, monitorMode});
		resetPinN = 1'b1;
		repeat (8) @(posedge core_clk);
		#1;
		check_val("normal baud", 16'h1, {15'h0, baudAltSel});
		check_val("normal divide", 16'h1, {15'h0, busDivFourSel});
		check_val("normal clock gen", 16'h0, {15'h0, internalClockGenOn});
		check_val("normal watchdog", 16'h1, {15'h0, watchdogDisable});
		rx("entry break", 8'h00, 1'b1, 1, 3);
		check_count("extra resets again", 1, extraCount);
		check_count("swi again", 2, swiCount);
		check_count("flag writes again", 1, flagCount);
		check_val("still unlocked", 16'h1, {15'h0, flashUnlocked});
	endtask

	task automatic t_read_stack();
		host.send_byte(8'h0c);
		rx("stack echo", 8'h0c, 1'b0, 1, 3);
		rx("stack high", 8'h13, 1'b0, 13, 15);
		rx("stack low", 8'h00, 1'b0, 2, 3);
	endtask

	task automatic t_indexed_read();
		#1 lastAccessLoad = 1'b1;
		lastAccessAddr = 16'hfffe;
		@(posedge core_clk);
		#1 lastAccessLoad = 1'b0;
		host.send_byte(8'h1a);
		rx("index echo", 8'h1a, 1'b0, 1, 3);
		rx("index first", memv(16'hffff), 1'b0, 13, 15);
		rx("index wrap", memv(16'h0000), 1'b0, 2, 3);
	endtask

	task automatic t_run();
		int n;
		int lows;
		lows = 0;
		host.send_byte(8'h28);
		rx("run echo", 8'h28, 1'b0, 1, 3);
		for (n = 0; n < 16 * BITC && runCount == 0; n++) begin
			@(posedge core_clk);
		end
		check_count("run pulses", 1, runCount);
		check_count("run held off", 1, int'(n >= 11 * BITC));
		repeat (4 * BITC) begin
			@(posedge core_clk);
			if (line !== 1'b1) lows++;
		end
		check_count("data after run", 0, lows);
	endtask

	// ****************************************
	// Main sequence and hang guard
	// ****************************************
	initial begin
		repeat (120000) @(posedge core_clk);
		miscompares++;
		$display("unexpected run length expected end seen timeout");
		summarize();
	end

	initial begin
		rst = 1'b1;
		resetPinN = 1'b0;
		testHighVoltage = 1'b0;
		irqPinHigh = 1'b1;
		baudSelectPin = 1'b1;
		resetVectorBlank = 1'b1;
		securityCode = 64'h8e71_c63b_a55a_0ff0;
		stackPointer = 16'h12ff;
		lastAccessLoad = 1'b0;
		lastAccessAddr = 16'h0000;
		flashFetch = 1'b0;
		repeat (20) @(posedge core_clk);
		#1 rst = 1'b0;
		t_reset_entry();
		t_security();
		t_pin_reset();
		t_read_stack();
		t_indexed_read();
		t_run();
		summarize();
	end
endmodule
